// >>> irt_pkg.sv
// Purpose: Shared constants for the infrared pulse timer control block
// Assumes: 32-bit APB, one register per aligned word
// Notes: Offsets not multiples of four, so printed offsets are indices
package irt_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] IRT_IDX_COMMON = 12'hd01;
  localparam logic [11:0] IRT_IDX_ENV_CTRL = 12'hd02;
  localparam logic [11:0] IRT_IDX_CARRIER_CNT = 12'hd04;
  localparam logic [11:0] IRT_IDX_ENV_LOAD_LO = 12'hd05;
  localparam logic [11:0] IRT_IDX_ENV_LOAD_HI = 12'hd06;
  localparam logic [11:0] IRT_IDX_CAPTURE_LO = 12'hd07;
  localparam logic [11:0] IRT_IDX_CAPTURE_HI = 12'hd08;
  localparam logic [11:0] IRT_IDX_STATUS = 12'hd09;
  // Common function register fields
  localparam int IRT_CF_MODE = 7;
  localparam int IRT_CF_EDGE_HI = 5;
  localparam int IRT_CF_EDGE_LO = 4;
  localparam int IRT_CF_SUB_HI = 3;
  localparam int IRT_CF_SUB_LO = 2;
  localparam int IRT_CF_CARRIER_INIT = 1;
  localparam int IRT_CF_ENV_INIT = 0;
  // Envelope control fields
  localparam int IRT_EC_ENABLE = 7;
  localparam int IRT_EC_SINGLE = 6;
  localparam int IRT_EC_TIMEOUT = 5;
  localparam int IRT_EC_CLK_HI = 4;
  localparam int IRT_EC_CLK_LO = 3;
  localparam int IRT_EC_CAP_MASK = 2;
  localparam int IRT_EC_CNT_MASK = 1;
  localparam int IRT_EC_ROUTE = 0;
  // Reset values
  localparam logic [7:0] IRT_COMMON_RST = 8'h00;
  localparam logic [7:0] IRT_ENV_CTRL_RST = 8'h00;
  localparam logic [15:0] IRT_ENV_LOAD_RST = 16'hffff;
  localparam logic [7:0] IRT_CARRIER_RST = 8'hff;
  // Submode codes
  localparam logic [1:0] IRT_SUB_NORMAL = 2'h0;
  localparam logic [1:0] IRT_SUB_PINGPONG = 2'h1;
  // Edge select codes
  localparam logic [1:0] IRT_EDGE_FALL = 2'h0;
  localparam logic [1:0] IRT_EDGE_RISE = 2'h1;
  localparam logic [1:0] IRT_EDGE_BOTH = 2'h2;
  // Prescaler width
  localparam int IRT_PRESCALE_W = 3;
endpackage

// >>> irt_sync3.sv
// Purpose: Three-stage synchroniser with agreement check for a pin
// Assumes: Input is asynchronous to ref_clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module irt_sync3
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // Shift chain; accept a change once stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end

  assign level_o = level_reg;
endmodule
`default_nettype wire

// >>> irt_timer_ctrl.sv
// Purpose: Control for the carrier and envelope infrared timers
// Assumes: APB slave on ref_clk_i, synchronous active-high reset
// Notes: Interrupt controller and sync register live elsewhere
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module irt_timer_ctrl
  import irt_pkg::*;
#(
  parameter int ENV_W = 16,
  parameter int CAR_W = 8
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Stop-mode recovery pulse
  input wire logic stop_recover_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Carrier enable from sync register
  input wire logic carrier_enable_i,
  // Pins
  input wire logic demod_pin_i,
  input wire logic port_data_i,
  output logic carrier_output_o,
  output logic envelope_output_o,
  output logic port3_pin5_o,
  // Interrupt request to the controller
  output logic timer_irq_o
);
  logic [7:0] common_function_reg;
  logic [7:0] envelope_timer_control;
  logic [ENV_W-1:0] env_load_reg;
  logic [ENV_W-1:0] env_count_reg;
  logic [ENV_W-1:0] capture_low_reg;
  logic [ENV_W-1:0] capture_high_reg;
  logic [CAR_W-1:0] car_load_reg;
  logic [CAR_W-1:0] car_count_reg;
  logic [IRT_PRESCALE_W-1:0] prescale_reg;
  logic env_out_reg;
  logic car_out_reg;
  logic car_en_d_reg;
  logic env_en_d_reg;
  logic first_done_reg;
  logic demod_d_reg;
  logic pp_phase_reg;
  logic irq_reg;
  logic demod_lvl;
  logic demod_mode;
  logic [1:0] submode;
  logic env_en;
  logic wr_en;
  logic rd_en;
  logic [11:0] idx;
  logic addr_hit;
  logic tick;
  logic terminal;
  logic rise_ev;
  logic fall_ev;
  logic sel_edge;
  logic capture_ev;
  logic rise_clr;
  logic fall_clr;
  logic to_clr;
  logic [31:0] rdata_next;

  // Demodulator pin enters through the synchroniser
  irt_sync3 u_demod_sync
  (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(demod_pin_i),
    .level_o(demod_lvl)
  );

  // APB decode; zero wait states, unmapped reads zero with error
  assign idx = paddr_i[13:2];
  assign addr_hit = (idx == IRT_IDX_COMMON) || (idx == IRT_IDX_ENV_CTRL) ||
                    (idx == IRT_IDX_CARRIER_CNT) || (idx == IRT_IDX_ENV_LOAD_LO) ||
                    (idx == IRT_IDX_ENV_LOAD_HI) || (idx == IRT_IDX_CAPTURE_LO) ||
                    (idx == IRT_IDX_CAPTURE_HI) || (idx == IRT_IDX_STATUS);
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  assign demod_mode = common_function_reg[IRT_CF_MODE];
  assign submode = common_function_reg[IRT_CF_SUB_HI:IRT_CF_SUB_LO];
  assign env_en = envelope_timer_control[IRT_EC_ENABLE];

  // Write-one-to-clear strobes for the sticky flags
  assign rise_clr = wr_en && (idx == IRT_IDX_COMMON) && demod_mode &&
                    pwdata_i[IRT_CF_CARRIER_INIT];
  assign fall_clr = wr_en && (idx == IRT_IDX_COMMON) && demod_mode &&
                    pwdata_i[IRT_CF_ENV_INIT];
  assign to_clr = wr_en && (idx == IRT_IDX_ENV_CTRL) && pwdata_i[IRT_EC_TIMEOUT];

  // Edge detection on the clean demodulator level
  assign rise_ev = demod_mode && demod_lvl && !demod_d_reg;
  assign fall_ev = demod_mode && !demod_lvl && demod_d_reg;
  always_comb
  begin
    case (common_function_reg[IRT_CF_EDGE_HI:IRT_CF_EDGE_LO])
      IRT_EDGE_FALL: sel_edge = fall_ev;
      IRT_EDGE_RISE: sel_edge = rise_ev;
      IRT_EDGE_BOTH: sel_edge = rise_ev || fall_ev;
      default: sel_edge = 1'b0; // Reserved code captures nothing
    endcase
  end
  // Single-edge capture takes only the first selected edge
  assign capture_ev = env_en && sel_edge &&
                      !(envelope_timer_control[IRT_EC_SINGLE] && first_done_reg);

  // Prescaled count tick from the clock select field
  always_comb
  begin
    case (envelope_timer_control[IRT_EC_CLK_HI:IRT_EC_CLK_LO])
      2'h0: tick = 1'b1;
      2'h1: tick = (prescale_reg[0] == 1'b1);
      2'h2: tick = (prescale_reg[1:0] == 2'h3);
      default: tick = (prescale_reg == 3'h7);
    endcase
  end
  assign terminal = !demod_mode && env_en && tick && (env_count_reg == '0);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !env_en)
      prescale_reg <= '0;
    else
      prescale_reg <= prescale_reg + 3'h1;
  end

  // Common function register; edge flags are sticky, set beats clear
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      common_function_reg <= IRT_COMMON_RST;
    else if (stop_recover_i)
      common_function_reg <= {common_function_reg[7:6], common_function_reg[5:4], 4'h0};
    else
    begin
      if (wr_en && (idx == IRT_IDX_COMMON))
      begin
        common_function_reg[7:2] <= pwdata_i[7:2];
        if (!demod_mode)
          common_function_reg[1:0] <= pwdata_i[1:0];
      end
      if (demod_mode)
      begin
        if (rise_ev)
          common_function_reg[IRT_CF_CARRIER_INIT] <= 1'b1;
        else if (rise_clr)
          common_function_reg[IRT_CF_CARRIER_INIT] <= 1'b0;
        if (fall_ev)
          common_function_reg[IRT_CF_ENV_INIT] <= 1'b1;
        else if (fall_clr)
          common_function_reg[IRT_CF_ENV_INIT] <= 1'b0;
      end
    end
  end

  // Envelope control; clock select and capture mask survive recovery
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      envelope_timer_control <= IRT_ENV_CTRL_RST;
    else if (stop_recover_i)
      envelope_timer_control <= {3'h0, envelope_timer_control[4:2], 2'h0};
    else
    begin
      if (wr_en && (idx == IRT_IDX_ENV_CTRL))
      begin
        envelope_timer_control[7:6] <= pwdata_i[7:6];
        envelope_timer_control[4:0] <= pwdata_i[4:0];
      end
      if (terminal)
        envelope_timer_control[IRT_EC_TIMEOUT] <= 1'b1;
      else if (to_clr)
        envelope_timer_control[IRT_EC_TIMEOUT] <= 1'b0;
      if (terminal && envelope_timer_control[IRT_EC_SINGLE])
        envelope_timer_control[IRT_EC_ENABLE] <= 1'b0;
    end
  end

  // Load values for both timers
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      env_load_reg <= IRT_ENV_LOAD_RST;
      car_load_reg <= IRT_CARRIER_RST;
    end
    else if (wr_en)
    begin
      if (idx == IRT_IDX_ENV_LOAD_LO)
        env_load_reg[7:0] <= pwdata_i[7:0];
      else if (idx == IRT_IDX_ENV_LOAD_HI)
        env_load_reg[ENV_W-1:8] <= pwdata_i[ENV_W-9:0];
      else if (idx == IRT_IDX_CARRIER_CNT)
        car_load_reg <= pwdata_i[CAR_W-1:0];
    end
  end

  // Envelope counter: down-count in transmit, free count in demod
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      env_count_reg <= IRT_ENV_LOAD_RST;
    else if (!env_en)
      env_count_reg <= env_load_reg;
    else if (demod_mode)
    begin
      if (capture_ev)
        env_count_reg <= env_load_reg;
      else if (tick)
        env_count_reg <= env_count_reg - 16'h1;
    end
    else if (terminal)
      env_count_reg <= env_load_reg;
    else if (tick)
      env_count_reg <= env_count_reg - 16'h1;
  end

  // Capture registers and first-edge tracking
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      capture_low_reg <= '0;
      capture_high_reg <= '0;
      first_done_reg <= 1'b0;
      demod_d_reg <= 1'b0;
    end
    else
    begin
      demod_d_reg <= demod_lvl;
      if (!env_en)
        first_done_reg <= 1'b0;
      else if (capture_ev)
        first_done_reg <= 1'b1;
      // Low phase ends on a rising edge, high phase on a falling one
      if (capture_ev && rise_ev)
        capture_low_reg <= env_load_reg - env_count_reg;
      if (capture_ev && fall_ev)
        capture_high_reg <= env_load_reg - env_count_reg;
    end
  end

  // Envelope output: idles inverted, steps at enable, toggles at terminal
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      env_out_reg <= 1'b1;
      env_en_d_reg <= 1'b0;
      pp_phase_reg <= 1'b0;
    end
    else
    begin
      env_en_d_reg <= env_en;
      if (submode[1])
        env_out_reg <= 1'b0;
      else if (!env_en)
        env_out_reg <= !common_function_reg[IRT_CF_ENV_INIT];
      else if (!env_en_d_reg)
        env_out_reg <= common_function_reg[IRT_CF_ENV_INIT];
      else if (terminal)
        env_out_reg <= !env_out_reg;
      // Ping-pong phase swaps on envelope terminal; normal ends it
      if (submode != IRT_SUB_PINGPONG || !env_en)
        pp_phase_reg <= 1'b0;
      else if (terminal)
        pp_phase_reg <= !pp_phase_reg;
    end
  end

  // Carrier output: simple toggle divider, held off in ping-pong envelope phase
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      car_out_reg <= 1'b1;
      car_count_reg <= IRT_CARRIER_RST;
      car_en_d_reg <= 1'b0;
    end
    else
    begin
      car_en_d_reg <= carrier_enable_i;
      if (!carrier_enable_i || demod_mode || pp_phase_reg)
      begin
        car_out_reg <= !common_function_reg[IRT_CF_CARRIER_INIT];
        car_count_reg <= car_load_reg;
      end
      else if (!car_en_d_reg)
        car_out_reg <= common_function_reg[IRT_CF_CARRIER_INIT];
      else if (car_count_reg == '0)
      begin
        car_out_reg <= !car_out_reg;
        car_count_reg <= car_load_reg;
      end
      else
        car_count_reg <= car_count_reg - 8'h1;
    end
  end

  // Interrupt request; masks gate events in their own cycle
  always_comb
  begin
    timer_irq_o = (terminal && envelope_timer_control[IRT_EC_CNT_MASK]) ||
                  (capture_ev && envelope_timer_control[IRT_EC_CAP_MASK]);
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= timer_irq_o;
  end

  // Read data mux; captured in setup so data comes from flip-flops
  always_comb
  begin
    rdata_next = 32'h0;
    if (idx == IRT_IDX_COMMON)
      rdata_next[7:0] = common_function_reg;
    else if (idx == IRT_IDX_ENV_CTRL)
      rdata_next[7:0] = envelope_timer_control;
    else if (idx == IRT_IDX_CARRIER_CNT)
      rdata_next[7:0] = car_load_reg;
    else if (idx == IRT_IDX_ENV_LOAD_LO)
      rdata_next[7:0] = env_load_reg[7:0];
    else if (idx == IRT_IDX_ENV_LOAD_HI)
      rdata_next[7:0] = env_load_reg[15:8];
    else if (idx == IRT_IDX_CAPTURE_LO)
      rdata_next[15:0] = capture_low_reg;
    else if (idx == IRT_IDX_CAPTURE_HI)
      rdata_next[15:0] = capture_high_reg;
    else if (idx == IRT_IDX_STATUS)
      rdata_next[3:0] = {irq_reg, pp_phase_reg, car_out_reg, env_out_reg};
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      prdata_o <= 32'h0;
    else if (rd_en)
      prdata_o <= rdata_next;
  end

  // Pin outputs; pin five routed by control bit
  assign envelope_output_o = env_out_reg;
  assign carrier_output_o = car_out_reg;
  assign port3_pin5_o = envelope_timer_control[IRT_EC_ROUTE] ? env_out_reg : port_data_i;
endmodule
`default_nettype wire

// >>> irt_timer_ctrl_assertions.sv
// Purpose: Port checks for the infrared timer control block
// Assumes: APB writes seen at the ports drive small shadows
// Notes: Only bits with a certain pin effect are shadowed
`timescale 1ns/1ps
`default_nettype none
module irt_timer_ctrl_assertions
  import irt_pkg::*;
#(
  parameter int ENV_W = 16,
  parameter int CAR_W = 8
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic stop_recover_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Pins
  input wire logic carrier_enable_i,
  input wire logic port_data_i,
  input wire logic carrier_output_o,
  input wire logic envelope_output_o,
  input wire logic port3_pin5_o,
  input wire logic timer_irq_o
);
  logic wr_cf;
  logic wr_ec;
  logic mode_q;
  logic capm_q;
  logic en_q;
  logic route_q;
  logic cntm_q;
  logic [1:0] sub_q;
  logic [1:0] init_q;
  logic [1:0] c_idle;
  logic [1:0] e_idle;
  // Completed writes to the two watched registers
  assign wr_cf = psel_i && penable_i && pwrite_i && paddr_i[13:2] == IRT_IDX_COMMON;
  assign wr_ec = psel_i && penable_i && pwrite_i && paddr_i[13:2] == IRT_IDX_ENV_CTRL;
  // Retained through stop recovery
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_q <= 1'b0;
      capm_q <= 1'b0;
    end
    else
    begin
      if (wr_cf)
        mode_q <= pwdata_i[7];
      if (wr_ec)
        capm_q <= pwdata_i[2];
    end
  end
  // Cleared by recovery; init bits only store in transmit mode
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || stop_recover_i)
    begin
      sub_q <= 2'h0;
      init_q <= 2'h0;
      en_q <= 1'b0;
      route_q <= 1'b0;
      cntm_q <= 1'b0;
    end
    else
    begin
      if (wr_cf)
        sub_q <= pwdata_i[3:2];
      if (wr_cf && !mode_q)
        init_q <= pwdata_i[1:0];
      if (wr_ec)
      begin
        en_q <= pwdata_i[7];
        route_q <= pwdata_i[0];
        cntm_q <= pwdata_i[1];
      end
    end
  end
  // Quiet counters, since outputs are registered behind the controls
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || stop_recover_i || wr_cf || carrier_enable_i)
      c_idle <= 2'h0;
    else if (c_idle != 2'h3)
      c_idle <= c_idle + 2'h1;
    if (sys_rst_i || stop_recover_i || wr_cf || wr_ec || en_q)
      e_idle <= 2'h0;
    else if (e_idle != 2'h3)
      e_idle <= e_idle + 2'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_bad_setup;
    psel_i && !penable_i && !pwrite_i && paddr_i[13:2] == 12'hd00;
  endsequence
  a_bad_read: assert property (s_bad_setup |=> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_bad_err: assert property (psel_i && penable_i && paddr_i[13:2] == 12'hd00 |-> pslverr_o)
    else $error("unmapped access without error");
  a_route_mux: assert property (
    port3_pin5_o == (route_q ? envelope_output_o : port_data_i))
    else $error("pin 5 routing wrong");
  a_carrier_idle: assert property (
    c_idle == 2'h3 && !mode_q && sub_q == 2'h0 |-> carrier_output_o == !init_q[1])
    else $error("idle carrier level wrong");
  a_carrier_step: assert property (
    $rose(carrier_enable_i) && !mode_q && sub_q == 2'h0 && c_idle == 2'h3
    |-> ##[1:2] carrier_output_o == init_q[1])
    else $error("carrier enable step missing");
  a_env_idle: assert property (
    e_idle == 2'h3 && !mode_q |-> envelope_output_o == (!sub_q[1] && !init_q[0]))
    else $error("idle envelope level wrong");
  a_env_step: assert property (
    wr_ec && pwdata_i[7] && e_idle == 2'h3 && !mode_q && sub_q == 2'h0
    |-> ##[1:2] envelope_output_o == init_q[0])
    else $error("envelope enable step missing");
  a_irq_masked: assert property (timer_irq_o |-> cntm_q || capm_q)
    else $error("interrupt with both masks off");
  a_irq_pulse: assert property (timer_irq_o |=> !timer_irq_o)
    else $error("interrupt longer than one cycle");
endmodule
bind irt_timer_ctrl irt_timer_ctrl_assertions #(.ENV_W(ENV_W), .CAR_W(CAR_W)) u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .stop_recover_i(stop_recover_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .carrier_enable_i(carrier_enable_i), .port_data_i(port_data_i),
  .carrier_output_o(carrier_output_o), .envelope_output_o(envelope_output_o),
  .port3_pin5_o(port3_pin5_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// >>> irt_ir_partner.sv
// Purpose: Demodulator input source facing the timer block
// Assumes: Bench sets the wanted level; line idles high
// Notes: Slow mode adds five cycles of lag
`timescale 1ns/1ps
`default_nettype none
module irt_ir_partner
(
  // Clock
  input wire logic ref_clk_i,
  // Requested level and lag choice
  input wire logic level_i,
  input wire logic slow_i,
  // Pin
  output logic pin_o
);
  logic [5:0] dly = 6'h3f;
  // Lag line; idle high so no edge appears at start
  always_ff @(posedge ref_clk_i)
    dly <= {dly[4:0], level_i};
  assign pin_o = slow_i ? dly[5] : dly[0];
endmodule
`default_nettype wire

// >>> ir_pulse_timer_control_bench.sv
// Purpose: Register-level tests of the infrared timer block
// Assumes: APB answers when pready is high at an edge
// Notes: Interrupt pulses are counted in the background
`timescale 1ns/1ps
`default_nettype none
module ir_pulse_timer_control_bench;
  import irt_pkg::*;
  localparam logic [15:0] A_CF = {2'h0, IRT_IDX_COMMON, 2'h0};
  localparam logic [15:0] A_EC = {2'h0, IRT_IDX_ENV_CTRL, 2'h0};
  localparam logic [15:0] A_LL = {2'h0, IRT_IDX_ENV_LOAD_LO, 2'h0};
  localparam logic [15:0] A_LH = {2'h0, IRT_IDX_ENV_LOAD_HI, 2'h0};
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic stop_rec = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic car_en = 1'b0;
  logic ir_level = 1'b1;
  logic slow = 1'b0;
  logic port_d = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd_val;
  logic pready;
  logic pslverr;
  logic rd_err;
  logic car_out;
  logic env_out;
  logic pin5;
  logic irq;
  logic demod_pin;
  int errors = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  int n0;
  int cnt[4];
  irt_timer_ctrl i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .stop_recover_i(stop_rec), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .carrier_enable_i(car_en), .demod_pin_i(demod_pin),
    .port_data_i(port_d), .carrier_output_o(car_out), .envelope_output_o(env_out),
    .port3_pin5_o(pin5), .timer_irq_o(irq));
  irt_ir_partner i_ir (.ref_clk_i(ref_clk_i), .level_i(ir_level), .slow_i(slow),
    .pin_o(demod_pin));
  // 25 MHz clock
  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Pulse count; the request is one cycle wide
  always @(posedge ref_clk_i)
    if (irq === 1'b1)
      irq_cnt++;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; idle cycle after so psel is never set twice at once
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    pen <= 1'b1;
    tick(1);
    // Wait states end only when pready comes or the watchdog fires
    while (pready !== 1'b1)
      tick(1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_val, e, "read");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    tick(12);
    sys_rst_i <= 1'b0;
    tick(1);
    rdc(A_EC, 32'h0);
    chk(car_out, 1'b1, "car");
    xfer(1'b0, 16'h3400, 32'h0);
    chk(rd_err, 1'b1, "slverr");
    // Initial levels, enable steps and forced envelope
    wr(A_CF, 32'h03);
    tick(2);
    chk(car_out, 1'b0, "car");
    chk(env_out, 1'b0, "env");
    car_en <= 1'b1;
    tick(2);
    chk(car_out, 1'b1, "car");
    car_en <= 1'b0; // Carrier stopped before its init bit moves
    wr(A_CF, 32'h08);
    tick(2);
    chk(env_out, 1'b0, "env");
    wr(A_CF, 32'h00);
    tick(2);
    chk(env_out, 1'b1, "env");
    wr(A_EC, 32'h80);
    tick(1);
    chk(env_out, 1'b0, "env");
    // Single pass with a short load; time-out cleared before use
    wr(A_LL, 32'h02);
    wr(A_LH, 32'h00);
    wr(A_EC, 32'h20);
    n0 = irq_cnt;
    wr(A_EC, 32'hc2);
    tick(30);
    chk(irq_cnt - n0, 1, "irq");
    rdc(A_EC, 32'h62);
    wr(A_EC, 32'h62);
    rdc(A_EC, 32'h42);
    wr(A_EC, 32'h02);
    tick(40);
    rdc(A_EC, 32'h02);
    // Time-out with its mask off
    wr(A_EC, 32'h80);
    n0 = irq_cnt;
    tick(40);
    chk(irq_cnt - n0, 0, "irq");
    rdc(A_EC, 32'ha0);
    // Modulo-N at each prescale setting
    for (int i = 0; i < 4; i++)
    begin
      n0 = irq_cnt;
      wr(A_EC, 32'h82 | 32'(i << 3));
      tick(192);
      wr(A_EC, 32'h20);
      cnt[i] = irq_cnt - n0;
    end
    chk(cnt[3] > 1, 1'b1, "reload");
    for (int i = 0; i < 3; i++)
      chk(cnt[i] + 3 >= 2 * cnt[i+1] && cnt[i] <= 2 * cnt[i+1] + 3, 1'b1, "div");
    // Routing and stop recovery
    wr(A_EC, 32'h1f);
    port_d <= 1'b0;
    tick(2);
    chk(pin5, 1'b1, "pin5"); // Idle envelope high, port low
    stop_rec <= 1'b1;
    tick(1);
    stop_rec <= 1'b0;
    tick(1);
    rdc(A_EC, 32'h1c);
    chk(pin5, 1'b0, "pin5");
    // Demodulation: both edges, flags and capture interrupt
    wr(A_CF, 32'ha0);
    wr(A_EC, 32'h84);
    n0 = irq_cnt;
    ir_level <= 1'b0;
    tick(14);
    rdc(A_CF, 32'ha1);
    chk(irq_cnt - n0, 1, "cap");
    slow <= 1'b1;
    ir_level <= 1'b1;
    tick(14);
    ir_level <= 1'b0;
    tick(14);
    rdc(A_CF, 32'ha3);
    wr(A_CF, 32'ha2);
    rdc(A_CF, 32'ha1);
    wr(A_CF, 32'ha1);
    rdc(A_CF, 32'ha0);
    // Rising-edge select: only the rise captures
    wr(A_CF, 32'h90);
    n0 = irq_cnt;
    ir_level <= 1'b1;
    tick(14);
    ir_level <= 1'b0;
    tick(14);
    chk(irq_cnt - n0, 1, "rise only");
    // Disable first so the single-edge capture rearms
    wr(A_CF, 32'ha0);
    wr(A_EC, 32'h04);
    wr(A_EC, 32'hc4);
    n0 = irq_cnt;
    ir_level <= 1'b1;
    tick(14);
    ir_level <= 1'b0;
    tick(14);
    chk(irq_cnt - n0, 1, "first");
    wr(A_EC, 32'h00);
    wr(A_CF, 32'ha3);
    wr(A_CF, 32'h00);
    rdc(A_CF, 32'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
